// >>> core/fdsc_pkg.sv
// constants, register map and carrier types of the finger detect scan controller
package fdsc_pkg;
  // register bus geometry
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // register offsets on the serial port
  localparam logic [6:0] REG_PGA      = 7'h01; // gain stages
  localparam logic [6:0] REG_DCOC     = 7'h02; // dc offset, msb is sign
  localparam logic [6:0] REG_THR      = 7'h08; // touch_threshold
  localparam logic [6:0] REG_FEN      = 7'h0a; // function_enable_reg
  localparam logic [6:0] REG_MODE     = 7'h0b; // op_mode_reg_alias
  localparam logic [6:0] REG_STAT     = 7'h0c; // status, read only
  localparam logic [6:0] REG_DROW     = 7'h10; // detect_row_select
  localparam logic [6:0] REG_LIFT     = 7'h11; // lift_check_row
  localparam logic [6:0] REG_TRIM     = 7'h13; // oscillator trim
  localparam logic [6:0] REG_RSV_A    = 7'h15; // reserved_cfg_a
  localparam logic [6:0] REG_RSV_B    = 7'h16; // reserved_cfg_b
  localparam logic [6:0] REG_RSV_C    = 7'h1d; // reserved_cfg_c
  localparam logic [6:0] REG_ID_HIGH  = 7'h1e; // chip_ident_high
  localparam logic [6:0] REG_ID_LOW   = 7'h1f; // chip_ident_low
  localparam logic [6:0] REG_CMD      = 7'h20; // start and soft reset strobes
  localparam logic [6:0] REG_OTP_BASE = 7'h40; // 32 read-only calibration bytes
  localparam logic [6:0] OTP_BYTES    = 7'h20;

  // reset values
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_RSV_B = 8'hdf;
  localparam logic [7:0] RST_MODE  = 8'h01; // chip active, interrupt off

  // field positions
  localparam int unsigned FEN_DET_BIT  = 5; // presence detect enable
  localparam int unsigned MODE_INT_BIT = 6; // touch pin enable
  localparam int unsigned MODE_CHIP_BIT = 0; // chip active
  localparam int unsigned STAT_FLAG_BIT = 5; // detection flag
  localparam int unsigned STAT_OK_BIT   = 6; // detect ok
  localparam int unsigned STAT_BUSY_BIT = 0; // scan in progress
  localparam int unsigned CMD_START_BIT = 0; // start image scan
  localparam int unsigned CMD_SRST_BIT  = 1; // software reset
  localparam int unsigned DC_SIGN_BIT   = 7;
  localparam int unsigned TRIM_W        = 6;

  // timing in pixel clocks
  localparam logic [7:0] LAT_COLD = 8'hb4; // 180 cycles
  localparam logic [7:0] LAT_WARM = 8'h13; // 19 cycles
  localparam logic [7:0] ROW_GAP  = 8'h0b; // 11 cycles
  localparam logic [7:0] WHITE    = 8'hff;

  // serial frame positions (bit counts, zero based)
  localparam logic [4:0] SPI_ADDR_END = 5'h07;
  localparam logic [4:0] SPI_DATA_END = 5'h0f;
  localparam logic [4:0] SPI_CNT_MAX  = 5'h1f;

  // scan sequencer states, one-hot
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_LAT  = 4'b0010,
    S_ROW  = 4'b0100,
    S_GAP  = 4'b1000
  } fdsc_state_e;

  // analog front end settings
  typedef struct packed {
    logic [1:0] first_stage_gain;
    logic [3:0] second_stage_gain;
    logic       dc_neg;
    logic [6:0] dc_mag;
    logic [5:0] osc_trim;
  } fdsc_afe_s;

  // image byte stream
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fdsc_img_s;
endpackage

// >>> core/fdsc_top.sv
// finger detect scan controller: register port, detection and scan sequencer
`timescale 1ns/1ps
`default_nettype none
module fdsc_top #(
  parameter logic [8:0]   ROWS      = 9'h100,
  parameter logic [8:0]   COLS      = 9'h0c0,
  parameter logic [7:0]   ID_HIGH   = 8'h3c, // arbitrary value
  parameter logic [7:0]   ID_LOW    = 8'h5a, // arbitrary value
  parameter logic [255:0] OTP_IMAGE = 256'h0
) (
  // system
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  // serial port, its own clock
  input  wire logic               spi_sclk,
  input  wire logic               spi_cs_n,
  input  wire logic               spi_mosi,
  output logic                    spi_miso_o,
  output logic                    spi_miso_oe,
  // touch interrupt pin
  output logic                    touch_irq_pin_o,
  output logic                    touch_irq_pin_oe,
  // pixel array side
  input  wire logic [7:0]         pix_in,
  output logic [7:0]              row_sel,
  output fdsc_pkg::fdsc_img_s     img_out,
  output logic                    chan_open,
  output fdsc_pkg::fdsc_afe_s     afe_cfg
);

  // sys domain state
  typedef struct packed {
    fdsc_pkg::fdsc_state_e st;
    logic [7:0]  r_thr, r_fen, r_mode, r_pga, r_dcoc, r_lift, r_drow;
    logic [5:0]  r_trim;
    logic [7:0]  r_rsv_a, r_rsv_b, r_rsv_c;
    logic        start_pend, soft_rst, img_mode, warm, lifted, flag, det_ok, irq_lvl;
    logic [7:0]  row, col, cnt;
    logic [15:0] sum;
    logic [2:0]  wr_s, rd_s;
    logic [7:0]  rd_data;
    fdsc_pkg::fdsc_img_s img;
    logic        irq_o, irq_oe, chan;
    fdsc_pkg::fdsc_afe_s afe;
    logic [7:0]  row_sel;
  } fdsc_sys_s;

  // link frame state, cleared while chip select is high
  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] sh, tx;
    logic       rw, miso, oe;
  } fdsc_frm_s;

  // link state that survives between frames
  typedef struct packed {
    logic [1:0] rs;
    logic       wr_tgl, rd_tgl;
    logic [6:0] wr_addr, rd_addr;
    logic [7:0] wr_data;
  } fdsc_xfr_s;

  fdsc_sys_s s, n;          // sys registers and next value
  fdsc_frm_s f, fn;         // frame registers
  fdsc_xfr_s x, xn;         // crossing registers
  logic      start_go;      // a scan leaves idle
  logic      det_end;       // detection row finished
  logic      lift_evt;      // finger lift seen in image scan
  logic      core_rst;      // soft or chip-bit reset
  logic [15:0] thr_full;    // threshold scaled to row sum
  logic [15:0] sum_nx;      // row sum including this pixel
  logic [7:0]  otp_mem [32]; // calibration bytes, fixed at build

  // calibration store is a constant image, no write path exists
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      otp_mem[i] = OTP_IMAGE[i*8 +: 8];
    end
  end

  // register read mux
  function automatic logic [7:0] rd_mux(input fdsc_sys_s v, input logic [6:0] a);
    logic [7:0] r;
    r = fdsc_pkg::RST_ZERO;
    case (a)
      fdsc_pkg::REG_PGA:     r = v.r_pga;
      fdsc_pkg::REG_DCOC:    r = v.r_dcoc;
      fdsc_pkg::REG_THR:     r = v.r_thr;
      fdsc_pkg::REG_FEN:     r = v.r_fen;
      fdsc_pkg::REG_MODE:    r = v.r_mode;
      fdsc_pkg::REG_DROW:    r = v.r_drow;
      fdsc_pkg::REG_LIFT:    r = v.r_lift;
      fdsc_pkg::REG_TRIM:    r = {2'h0, v.r_trim};
      fdsc_pkg::REG_RSV_A:   r = v.r_rsv_a;
      fdsc_pkg::REG_RSV_B:   r = v.r_rsv_b;
      fdsc_pkg::REG_RSV_C:   r = v.r_rsv_c;
      fdsc_pkg::REG_ID_HIGH: r = ID_HIGH;
      fdsc_pkg::REG_ID_LOW:  r = ID_LOW;
      fdsc_pkg::REG_STAT: begin
        r[fdsc_pkg::STAT_FLAG_BIT] = v.flag;
        r[fdsc_pkg::STAT_OK_BIT]   = v.det_ok;
        r[fdsc_pkg::STAT_BUSY_BIT] = (v.st != fdsc_pkg::S_IDLE);
      end
      default: begin
        // calibration window, anything else reads zero
        if (a >= fdsc_pkg::REG_OTP_BASE && a < fdsc_pkg::REG_OTP_BASE + fdsc_pkg::OTP_BYTES) begin
          r = otp_mem[a[4:0]];
        end
      end
    endcase
    return r;
  endfunction

  // sys domain next state
  always_comb begin
    n        = s;
    start_go = 1'b0;
    det_end  = 1'b0;
    lift_evt = 1'b0;
    thr_full = {s.r_thr, 8'h00};
    sum_nx   = s.sum + {8'h00, pix_in};
    core_rst = s.soft_rst | ~s.r_mode[fdsc_pkg::MODE_CHIP_BIT];
    n.soft_rst = 1'b0;
    n.img.valid = 1'b0;
    // toggle synchronisers, first stage feeds only the second
    n.wr_s = {s.wr_s[1:0], x.wr_tgl};
    n.rd_s = {s.rd_s[1:0], x.rd_tgl};
    // write from the serial port; words are stable while the toggle settles
    if (s.wr_s[2] ^ s.wr_s[1]) begin
      case (x.wr_addr)
        fdsc_pkg::REG_PGA:   n.r_pga  = x.wr_data;
        fdsc_pkg::REG_DCOC:  n.r_dcoc = x.wr_data;
        fdsc_pkg::REG_THR:   n.r_thr  = x.wr_data;
        fdsc_pkg::REG_FEN: begin
          n.r_fen = x.wr_data;
          // detection switched off: next scan pays the long latency
          if (s.r_fen[fdsc_pkg::FEN_DET_BIT] && !x.wr_data[fdsc_pkg::FEN_DET_BIT]) begin
            n.warm = 1'b0;
          end
        end
        fdsc_pkg::REG_MODE:  n.r_mode  = x.wr_data;
        fdsc_pkg::REG_DROW:  n.r_drow  = x.wr_data;
        fdsc_pkg::REG_LIFT:  n.r_lift  = x.wr_data;
        fdsc_pkg::REG_TRIM:  n.r_trim  = x.wr_data[fdsc_pkg::TRIM_W-1:0];
        fdsc_pkg::REG_RSV_A: n.r_rsv_a = x.wr_data;
        fdsc_pkg::REG_RSV_B: n.r_rsv_b = x.wr_data;
        fdsc_pkg::REG_RSV_C: n.r_rsv_c = x.wr_data;
        fdsc_pkg::REG_CMD: begin
          if (x.wr_data[fdsc_pkg::CMD_START_BIT]) begin
            n.start_pend = 1'b1;
          end
          if (x.wr_data[fdsc_pkg::CMD_SRST_BIT]) begin
            n.soft_rst = 1'b1;
          end
        end
        default: ; // read-only or unmapped, write ignored
      endcase
    end
    // read request: answer word stays put until the next request
    if (s.rd_s[2] ^ s.rd_s[1]) begin
      n.rd_data = rd_mux(s, x.rd_addr);
    end
    // scan sequencer
    case (s.st)
      fdsc_pkg::S_IDLE: begin
        // image request wins; detection otherwise restarts at once
        if (s.start_pend || s.r_fen[fdsc_pkg::FEN_DET_BIT]) begin
          start_go     = 1'b1;
          n.img_mode   = s.start_pend;
          // a start written in this very cycle stays pending unless an image scan starts now
          n.start_pend = n.start_pend & ~s.start_pend;
          n.flag       = 1'b0;
          n.cnt        = (s.warm ? fdsc_pkg::LAT_WARM : fdsc_pkg::LAT_COLD) - 8'h01;
          // detection switched off in this cycle keeps the long latency
          n.warm       = ~(s.r_fen[fdsc_pkg::FEN_DET_BIT] & ~n.r_fen[fdsc_pkg::FEN_DET_BIT]);
          n.lifted     = 1'b0;
          n.st         = fdsc_pkg::S_LAT;
        end
      end
      fdsc_pkg::S_LAT: begin
        if (s.cnt == 8'h00) begin
          n.st  = fdsc_pkg::S_ROW;
          n.col = 8'h00;
          n.sum = 16'h0000;
          n.row = s.img_mode ? 8'h00 : s.r_drow;
        end else begin
          n.cnt = s.cnt - 8'h01;
        end
      end
      fdsc_pkg::S_ROW: begin
        // one pixel per cycle
        n.sum = sum_nx;
        n.col = s.col + 8'h01;
        if (s.img_mode) begin
          // closed channel or lifted finger gives white pixels
          n.img.valid = 1'b1;
          n.img.data  = (s.lifted || !(s.det_ok || s.flag)) ? fdsc_pkg::WHITE : pix_in;
        end
        if ({1'b0, s.col} == COLS - 9'h001) begin
          if (!s.img_mode) begin
            // detection row done: pixels never reach the stream
            det_end  = 1'b1;
            n.flag   = (sum_nx > thr_full);
            n.det_ok = (sum_nx > thr_full);
            if (sum_nx > thr_full) begin
              n.irq_lvl = 1'b0;
            end
            n.st = fdsc_pkg::S_IDLE;
          end else begin
            if (s.row == s.r_lift && sum_nx < thr_full) begin
              lift_evt  = 1'b1;
              n.lifted  = 1'b1;
              n.flag    = 1'b0;
              n.det_ok  = 1'b0;
              n.irq_lvl = 1'b1;
            end
            if ({1'b0, s.row} == ROWS - 9'h001) begin
              n.st = fdsc_pkg::S_IDLE;
            end else begin
              n.st  = fdsc_pkg::S_GAP;
              n.cnt = fdsc_pkg::ROW_GAP - 8'h01;
            end
          end
        end
      end
      fdsc_pkg::S_GAP: begin
        if (s.cnt == 8'h00) begin
          n.st  = fdsc_pkg::S_ROW;
          n.row = s.row + 8'h01;
          n.col = 8'h00;
          n.sum = 16'h0000;
        end else begin
          n.cnt = s.cnt - 8'h01;
        end
      end
      default: n.st = fdsc_pkg::S_IDLE;
    endcase
    // pin idles high whenever interrupts are off
    if (!s.r_mode[fdsc_pkg::MODE_INT_BIT]) begin
      n.irq_lvl = 1'b1;
    end
    // soft and chip-bit reset stop the logic but keep registers and port
    if (core_rst) begin
      n.st         = fdsc_pkg::S_IDLE;
      n.flag       = 1'b0;
      n.det_ok     = 1'b0;
      n.warm       = 1'b0;
      n.lifted     = 1'b0;
      n.start_pend = 1'b0;
      n.irq_lvl    = 1'b1;
      n.img.valid  = 1'b0;
    end
    // registered outputs
    n.irq_o   = s.irq_lvl;
    n.irq_oe  = s.r_mode[fdsc_pkg::MODE_INT_BIT];
    n.chan    = n.det_ok | n.flag;
    n.row_sel = n.row;
    n.afe.first_stage_gain  = s.r_pga[5:4];
    n.afe.second_stage_gain = s.r_pga[3:0];
    n.afe.dc_neg            = s.r_dcoc[fdsc_pkg::DC_SIGN_BIT];
    n.afe.dc_mag            = s.r_dcoc[6:0];
    n.afe.osc_trim          = s.r_trim;
  end

  // sys domain registers, frozen while clk_en is low unless reset is held
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s            <= '0;
      s.st         <= fdsc_pkg::S_IDLE;
      s.r_mode     <= fdsc_pkg::RST_MODE;
      s.r_rsv_b    <= fdsc_pkg::RST_RSV_B;
      s.irq_lvl    <= 1'b1;
      s.irq_o      <= 1'b1;
    end else if (clk_en) begin
      s <= n;
    end
  end

  // link frame next state
  always_comb begin
    fn     = f;
    fn.sh  = {f.sh[6:0], spi_mosi};
    fn.oe  = 1'b1;
    fn.tx  = {f.tx[6:0], 1'b0};
    fn.miso = f.tx[6];
    if (f.cnt != fdsc_pkg::SPI_CNT_MAX) begin
      fn.cnt = f.cnt + 5'h01;
    end
    if (f.cnt == fdsc_pkg::SPI_ADDR_END) begin
      fn.rw = f.sh[6];
    end
    // read answer was settled in sys domain during the dummy byte
    if (f.cnt == fdsc_pkg::SPI_DATA_END) begin
      fn.tx   = s.rd_data;
      fn.miso = s.rd_data[7];
    end
  end

  // link crossing next state
  always_comb begin
    xn    = x;
    xn.rs = {x.rs[0], rst_n};
    if (!x.rs[1]) begin
      // only the reset pin reaches the serial port
      xn.wr_tgl = 1'b0;
      xn.rd_tgl = 1'b0;
    end else if (!spi_cs_n) begin
      if (f.cnt == fdsc_pkg::SPI_ADDR_END && f.sh[6]) begin
        xn.rd_addr = {f.sh[5:0], spi_mosi};
        xn.rd_tgl  = ~x.rd_tgl;
      end
      if (f.cnt == fdsc_pkg::SPI_ADDR_END) begin
        xn.wr_addr = {f.sh[5:0], spi_mosi};
      end
      if (f.cnt == fdsc_pkg::SPI_DATA_END && !f.rw) begin
        xn.wr_data = {f.sh[6:0], spi_mosi};
        xn.wr_tgl  = ~x.wr_tgl;
      end
    end
  end

  // frame state clears whenever the host deselects
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      f <= '0;
    end else begin
      f <= fn;
    end
  end

  // crossing words live across frames
  always_ff @(posedge spi_sclk) begin
    x <= xn;
  end

  // outputs straight from flops
  assign spi_miso_o       = f.miso;
  assign spi_miso_oe      = f.oe;
  assign touch_irq_pin_o  = s.irq_o;
  assign touch_irq_pin_oe = s.irq_oe;
  assign row_sel          = s.row_sel;
  assign img_out          = s.img;
  assign chan_open        = s.chan;
  assign afe_cfg          = s.afe;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_go_cold;
    clk_en && start_go && !s.warm && !core_rst;
  endsequence
  sequence seq_lat_loaded;
    s.st == fdsc_pkg::S_LAT && s.cnt == fdsc_pkg::LAT_COLD - 8'h01;
  endsequence

  AST_DET_ENABLED: assert property (clk_en && start_go && !s.start_pend
                                    |-> s.r_fen[fdsc_pkg::FEN_DET_BIT])
    else $error("detection scan started while detection disabled");
  AST_PIN_ENABLE: assert property (clk_en
                                   |=> touch_irq_pin_oe == $past(s.r_mode[fdsc_pkg::MODE_INT_BIT]))
    else $error("touch pin enable does not follow interrupt enable");
  AST_NO_DET_STREAM: assert property (clk_en && s.st == fdsc_pkg::S_ROW && !s.img_mode
                                      |=> !img_out.valid)
    else $error("detection row reached the image stream");
  AST_DET_RESULT: assert property (clk_en && det_end && !core_rst
                                   |=> s.det_ok == $past(sum_nx > thr_full)
                                       && s.flag == s.det_ok)
    else $error("detection result does not match sum against threshold");
  AST_WHITE_CLOSED: assert property (clk_en && s.st == fdsc_pkg::S_ROW && s.img_mode
                                     && !s.det_ok && !s.flag |=> img_out.data == fdsc_pkg::WHITE)
    else $error("closed channel passed pixel data");
  AST_FLAG_CLR_START: assert property (clk_en && start_go |=> !s.flag)
    else $error("flag survived a scan start");
  AST_SOFT_RESET: assert property (clk_en && core_rst |=> !s.flag && !s.det_ok
                                   && s.st == fdsc_pkg::S_IDLE)
    else $error("reset left status bits set");
  AST_LIFT: assert property (clk_en && lift_evt && !core_rst
                             |=> s.irq_lvl && !s.flag && !s.det_ok && s.lifted)
    else $error("lift did not raise pin and clear status");
  AST_COLD_LAT: assert property (seq_go_cold |=> seq_lat_loaded)
    else $error("cold latency not loaded");
  AST_ROW_GAP: assert property (clk_en && s.st == fdsc_pkg::S_ROW && n.st == fdsc_pkg::S_GAP
                                && !core_rst |=> s.cnt == fdsc_pkg::ROW_GAP - 8'h01)
    else $error("row gap count wrong");

endmodule
`default_nettype wire

// >>> verification/fdsc_host.sv
// host microcontroller model on the serial port of the sensor
`timescale 1ns/1ps
`default_nettype none
module fdsc_host (
  // serial port pins
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso_o,
  input  wire logic spi_miso_oe
);
  realtime t_last; // 16th rise of the latest frame
  logic    gap;    // a write frame was the last one
  // clock stands low and select high between frames
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    gap = 1'b0;
  end
  // deselected clocking, lets link logic see reset
  task automatic kick(input int n);
    repeat (n) begin
      #16 spi_sclk = 1'b1;
      #16 spi_sclk = 1'b0;
    end
  endtask
  // one frame, read answer sampled on rises 17..24
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] r);
    logic [23:0] sh;
    sh = {rd, a, d, 8'h00};
    r = 8'h00;
    // spacing after a write, kept before the frame so latency is seen
    if (gap) #512;
    gap = !rd;
    spi_cs_n = 1'b0;
    for (int i = 0; i < (rd ? 24 : 16); i++) begin
      spi_mosi = sh[23 - i];
      #16;
      // bit launched on the previous rise
      if (i >= 16) r = {r[6:0], spi_miso_o};
      spi_sclk = 1'b1;
      if (i == 15) t_last = $realtime;
      #16 spi_sclk = 1'b0;
    end
    spi_cs_n = 1'b1;
    // released line shows no stale level
    spi_mosi = ~spi_mosi;
    // select stays high a bit time so the frame state really clears
    #32;
  endtask
endmodule
`default_nettype wire

// >>> verification/fdsc_top_tb.sv
// self-checking bench of the finger detect scan controller
`timescale 1ns/1ps
`default_nettype none
module fdsc_top_tb;
  logic                sys_clk;     // pixel clock
  logic                rst_n;       // reset pin
  logic                clk_en;      // core enable, dropped once to freeze
  wire logic           spi_sclk;    // host clock
  wire logic           spi_cs_n;    // host select
  wire logic           spi_mosi;    // host data
  logic                spi_miso_o;  // device data
  logic                spi_miso_oe; // device data enable
  logic                irq_o;       // touch pin level
  logic                irq_oe;      // touch pin enable
  logic [7:0]          pix_in;      // pixel byte
  logic [7:0]          row_sel;     // scanned row
  fdsc_pkg::fdsc_img_s img_out;     // image stream
  logic                chan_open;   // channel state
  fdsc_pkg::fdsc_afe_s afe_cfg;     // front end settings
  logic [7:0]          pix_lvl;     // level of ordinary rows
  logic [7:0]          low_row;     // dark row, none at 0xff
  int                  fail_count;
  int                  checked;

  // small array keeps scans short
  fdsc_top #(.ROWS(9'h004), .COLS(9'h008),
    .ID_HIGH(8'h2d), .ID_LOW(8'h71), // arbitrary values
    .OTP_IMAGE({32{8'ha6}})) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
    .touch_irq_pin_o(irq_o), .touch_irq_pin_oe(irq_oe),
    .pix_in(pix_in), .row_sel(row_sel), .img_out(img_out),
    .chan_open(chan_open), .afe_cfg(afe_cfg));

  fdsc_host host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe));

  // pixel array answers the selected row at once
  assign pix_in = (row_sel == low_row) ? 8'h00 : pix_lvl;

  // clock
  always #2 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer(1'b0, a, d, r);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] r;
    host.xfer(1'b1, a, 8'h00, r);
    chk({24'h0, r & m}, {24'h0, e});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // bounded wait on the channel level
  task automatic wait_chan(input logic v, input int n);
    for (int i = 0; i < n && chan_open !== v; i++) idle(1);
    chk({31'h0, chan_open}, {31'h0, v});
  endtask
  // gathers one frame, timing taken from the last command rise
  task automatic collect(input int lo, input int hi, input logic [31:0] rowv);
    int k;
    int prev;
    int n;
    k = 0;
    prev = 0;
    for (int c = 0; c < 800 && k < 32; c++) begin
      idle(1);
      if (img_out.valid === 1'b1) begin
        n = int'(($realtime - host.t_last) / 4.0);
        if (k == 0) chk({31'h0, n >= lo && n <= hi}, 32'h1);
        else chk(32'(c - prev), (k % 8 == 0) ? 32'd12 : 32'd1);
        chk({24'h0, img_out.data}, {24'h0, rowv[8 * (k / 8) +: 8]});
        prev = c;
        k++;
      end
    end
    chk(32'(k), 32'd32);
  endtask

  task automatic t_regs;
    rd_chk(fdsc_pkg::REG_RSV_A, 8'hff, 8'h00);
    rd_chk(fdsc_pkg::REG_RSV_B, 8'hff, 8'hdf);
    rd_chk(fdsc_pkg::REG_RSV_C, 8'hff, 8'h00);
    wr(fdsc_pkg::REG_RSV_A, 8'h5c);
    rd_chk(fdsc_pkg::REG_RSV_A, 8'hff, 8'h5c);
    // read-only places keep their content
    wr(fdsc_pkg::REG_ID_HIGH, 8'h00);
    wr(fdsc_pkg::REG_OTP_BASE, 8'h00);
    rd_chk(fdsc_pkg::REG_ID_HIGH, 8'hff, 8'h2d);
    rd_chk(fdsc_pkg::REG_ID_LOW, 8'hff, 8'h71);
    rd_chk(fdsc_pkg::REG_OTP_BASE, 8'hff, 8'ha6);
    rd_chk(7'h5f, 8'hff, 8'ha6);
    rd_chk(7'h7f, 8'hff, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_afe;
    wr(fdsc_pkg::REG_PGA, 8'h3e);
    wr(fdsc_pkg::REG_DCOC, 8'h85);
    wr(fdsc_pkg::REG_TRIM, 8'h3e);
    idle(4);
    chk({12'h0, afe_cfg}, 32'h000fa17e);
    // frozen core holds its settings, the pending write lands on enable
    clk_en = 1'b0;
    wr(fdsc_pkg::REG_PGA, 8'h00);
    idle(8);
    chk({12'h0, afe_cfg}, 32'h000fa17e);
    clk_en = 1'b1;
    idle(8);
    chk({12'h0, afe_cfg}, 32'h0000217e);
    $display("test afe done");
  endtask

  task automatic t_detect;
    wr(fdsc_pkg::REG_MODE, 8'h41);
    idle(4);
    chk({30'h0, irq_oe, irq_o}, 32'h3);
    wr(fdsc_pkg::REG_THR, 8'h07);
    wr(fdsc_pkg::REG_DROW, 8'h01);
    pix_lvl = 8'hff;
    idle(600);
    chk({31'h0, chan_open}, 32'h0);
    wr(fdsc_pkg::REG_FEN, 8'h20);
    wait_chan(1'b1, 800);
    // pin level trails the channel by one register stage
    idle(2);
    chk({31'h0, irq_o}, 32'h0);
    rd_chk(fdsc_pkg::REG_STAT, 8'h40, 8'h40);
    pix_lvl = 8'h10;
    wait_chan(1'b0, 800);
    rd_chk(fdsc_pkg::REG_STAT, 8'h60, 8'h00);
    pix_lvl = 8'hff;
    wait_chan(1'b1, 800);
    $display("test detect done");
  endtask

  task automatic t_scan;
    wr(fdsc_pkg::REG_FEN, 8'h00);
    wr(fdsc_pkg::REG_LIFT, 8'h02);
    low_row = 8'h02;
    pix_lvl = 8'h90;
    wr(fdsc_pkg::REG_CMD, 8'h01);
    collect(180, 192, 32'hff009090);
    chk({30'h0, irq_o, chan_open}, 32'h2);
    rd_chk(fdsc_pkg::REG_STAT, 8'h60, 8'h00);
    low_row = 8'hff;
    wr(fdsc_pkg::REG_CMD, 8'h01);
    collect(19, 31, 32'hffffffff);
    $display("test scan done");
  endtask

  task automatic t_reset;
    wr(fdsc_pkg::REG_FEN, 8'h20);
    pix_lvl = 8'hff;
    wait_chan(1'b1, 800);
    wr(fdsc_pkg::REG_CMD, 8'h02);
    wait_chan(1'b0, 8);
    rd_chk(fdsc_pkg::REG_THR, 8'hff, 8'h07);
    wait_chan(1'b1, 800);
    wr(fdsc_pkg::REG_MODE, 8'h40);
    wait_chan(1'b0, 8);
    rd_chk(fdsc_pkg::REG_STAT, 8'h60, 8'h00);
    wr(fdsc_pkg::REG_MODE, 8'h01);
    idle(4);
    chk({31'h0, irq_oe}, 32'h0);
    $display("test reset done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence, reset outlasts three link clock edges
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    pix_lvl = 8'h10;
    low_row = 8'hff;
    fail_count = 0;
    checked = 0;
    host.kick(3);
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    host.kick(3);
    t_regs;
    t_afe;
    t_detect;
    t_scan;
    t_reset;
    complete_run;
  end

  // watchdog, well beyond the expected run
  initial begin
    #300000;
    fail_count++;
    complete_run;
  end
endmodule
`default_nettype wire
